// File: core/ssc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_top #(
  parameter bit FLASH_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic core_stall,
  output logic mem_sleep,
  output logic mem_enable,
  output logic opcode_trap_sel,
  output logic single_shunt_amp_enable,
  output logic leg_shunt_amp_enable,
  output logic ac_sense_amp_enable,
  input wire logic itrip_trigger,
  input wire logic shutdown_in,
  output logic shutdown_out,
  output logic shutdown_oe,
  output logic pwm_shutoff
);
  typedef struct packed {
    ssc_pkg::ssc_state_t st;
    logic [11:0] cnt;
    logic [7:0] ext_op;
    logic [7:0] hw_cfg;
    logic [7:0] sleep_val;
    logic [7:0] run_val;
    logic [7:0] clock3;
    logic [7:0] shutdown_cfg;
    logic [7:0] rdata;
    logic stall;
    logic sleep;
    logic enable;
    logic oe;
    logic pwm_off;
  } ssc_regs_t;

  ssc_regs_t r_q;
  ssc_regs_t r_d;

  // Sleep time in cycles, zero for a zero value.
  function automatic logic [11:0] sleep_cycles(input logic [7:0] v);
    sleep_cycles = {v, 4'h0};
  endfunction

  // Reset image: memory asleep and core stalled while in reset.
  localparam ssc_regs_t RESET_IMAGE = '{
    st: ssc_pkg::SSC_RUN, cnt: 12'h000,
    ext_op: ssc_pkg::EXT_OP_RESET, hw_cfg: ssc_pkg::HW_CFG_RESET,
    sleep_val: 8'h00, run_val: 8'h00, clock3: ssc_pkg::CLOCK3_RESET,
    shutdown_cfg: ssc_pkg::SHUTDOWN_RESET, rdata: 8'h00,
    stall: 1'b1, sleep: 1'b1, enable: 1'b0, oe: 1'b1, pwm_off: 1'b1};

  // Register file, sleep sequencer and shutdown logic.
  always_comb begin
    logic kill;
    logic [3:0] lead;
    kill = 1'b0;
    lead = r_q.clock3[ssc_pkg::LEAD_LSB +: 4];
    r_d = r_q;
    r_d.rdata = 8'h00;
    // Register writes; reserved bits masked off.
    if (sfr_wr) begin
      case (sfr_addr)
        ssc_pkg::ADDR_EXT_OP: r_d.ext_op = sfr_wdata & ssc_pkg::EXT_OP_MASK;
        ssc_pkg::ADDR_HW_CFG: r_d.hw_cfg = sfr_wdata & ssc_pkg::HW_CFG_MASK;
        ssc_pkg::ADDR_RUN: r_d.run_val = sfr_wdata;
        ssc_pkg::ADDR_CLOCK3: r_d.clock3 = sfr_wdata & ssc_pkg::CLOCK3_MASK;
        ssc_pkg::ADDR_SHUTDOWN: r_d.shutdown_cfg = sfr_wdata & ssc_pkg::SHUTDOWN_MASK;
        ssc_pkg::ADDR_SLEEP: r_d.sleep_val = sfr_wdata;
        default: r_d.cnt = r_q.cnt; // Revision and unmapped writes are ignored.
      endcase
    end
    // Register reads; unmapped addresses return zero.
    if (sfr_rd) begin
      case (sfr_addr)
        ssc_pkg::ADDR_EXT_OP: r_d.rdata = r_q.ext_op;
        ssc_pkg::ADDR_HW_CFG: r_d.rdata = r_q.hw_cfg;
        ssc_pkg::ADDR_SLEEP: r_d.rdata = r_q.sleep_val;
        ssc_pkg::ADDR_RUN: r_d.rdata = r_q.run_val;
        ssc_pkg::ADDR_CLOCK3: r_d.rdata = r_q.clock3;
        ssc_pkg::ADDR_REV: r_d.rdata = ssc_pkg::REVISION_CODE;
        ssc_pkg::ADDR_SHUTDOWN: r_d.rdata = r_q.shutdown_cfg;
        default: r_d.rdata = 8'h00;
      endcase
    end
    // Sleep sequencer; the motion engine is never touched here.
    case (r_q.st)
      ssc_pkg::SSC_RUN: begin
        r_d.cnt = 12'h000;
      end
      ssc_pkg::SSC_SLEEP: begin
        if (r_q.cnt <= 12'h001) begin
          r_d.st = ssc_pkg::SSC_LEAD;
          r_d.cnt = {8'h00, lead};
        end else begin
          r_d.cnt = r_q.cnt - 12'h001;
        end
      end
      ssc_pkg::SSC_LEAD: begin
        if (r_q.cnt == 12'h000 || FLASH_VARIANT) begin
          r_d.st = (r_q.run_val != 8'h00) ? ssc_pkg::SSC_AWAKE : ssc_pkg::SSC_RUN;
          r_d.cnt = {4'h0, r_q.run_val};
        end else begin
          r_d.cnt = r_q.cnt - 12'h001;
        end
      end
      ssc_pkg::SSC_AWAKE: begin
        if (r_q.run_val == 8'h00) begin
          r_d.st = ssc_pkg::SSC_RUN;
        end else if (r_q.cnt <= 12'h001) begin
          if (r_q.sleep_val != 8'h00) begin
            r_d.st = ssc_pkg::SSC_SLEEP;
            r_d.cnt = sleep_cycles(r_q.sleep_val);
          end else begin
            r_d.st = ssc_pkg::SSC_RUN;
          end
        end else begin
          r_d.cnt = r_q.cnt - 12'h001;
        end
      end
      default: r_d.st = ssc_pkg::SSC_RUN;
    endcase
    // A nonzero sleep write starts a sleep period at once.
    if (sfr_wr && sfr_addr == ssc_pkg::ADDR_SLEEP && sfr_wdata != 8'h00) begin
      r_d.st = ssc_pkg::SSC_SLEEP;
      r_d.cnt = sleep_cycles(sfr_wdata);
    end
    r_d.sleep = (r_d.st == ssc_pkg::SSC_SLEEP);
    r_d.enable = !r_d.sleep && !FLASH_VARIANT;
    r_d.stall = r_d.sleep || r_d.st == ssc_pkg::SSC_LEAD;
    // Shutdown line control.
    kill = !r_d.shutdown_cfg[ssc_pkg::RELEASE_BIT];
    if (r_d.shutdown_cfg[ssc_pkg::ITRIP_BIT] && itrip_trigger) begin
      kill = 1'b1;
    end
    r_d.oe = kill;
    r_d.pwm_off = kill || !shutdown_in;
  end

  // State register; reset holds memory asleep and shutdown asserted.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_q <= RESET_IMAGE;
    end else begin
      r_q <= r_d;
    end
  end

  assign sfr_rdata = r_q.rdata;
  assign core_stall = r_q.stall;
  assign mem_sleep = r_q.sleep;
  assign mem_enable = r_q.enable;
  assign opcode_trap_sel = r_q.ext_op[ssc_pkg::TRAP_EN_BIT];
  assign single_shunt_amp_enable = r_q.hw_cfg[0];
  assign leg_shunt_amp_enable = r_q.hw_cfg[2];
  assign ac_sense_amp_enable = r_q.hw_cfg[4];
  assign shutdown_out = 1'b0; // Open drain: low only.
  assign shutdown_oe = r_q.oe;
  assign pwm_shutoff = r_q.pwm_off;
endmodule // ssc_top
`default_nettype wire

// File: core/ssc_pkg.sv
package ssc_pkg;
  localparam logic [7:0] ADDR_EXT_OP = 8'ha2;
  localparam logic [7:0] ADDR_HW_CFG = 8'hb2;
  localparam logic [7:0] ADDR_SLEEP = 8'hc4;
  localparam logic [7:0] ADDR_RUN = 8'hc5;
  localparam logic [7:0] ADDR_REV = 8'hdc;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'he5;
  localparam logic [7:0] ADDR_CLOCK3 = 8'hdb;
  localparam int TRAP_EN_BIT = 4;
  localparam int RELEASE_BIT = 0;
  localparam int ITRIP_BIT = 2;
  localparam int LEAD_LSB = 3;
  localparam logic [7:0] EXT_OP_MASK = 8'h10;
  localparam logic [7:0] HW_CFG_MASK = 8'h15;
  localparam logic [7:0] SHUTDOWN_MASK = 8'h05;
  localparam logic [7:0] CLOCK3_MASK = 8'h78;
  localparam logic [7:0] EXT_OP_RESET = 8'h00;
  localparam logic [7:0] HW_CFG_RESET = 8'h01;
  localparam logic [7:0] SHUTDOWN_RESET = 8'h00;
  localparam logic [7:0] CLOCK3_RESET = 8'h00;
  localparam logic [7:0] REVISION_CODE = 8'h5a; // Arbitrary value.
  localparam int SLEEP_SHIFT = 4;
  typedef enum logic [3:0] {
    SSC_RUN = 4'h1,
    SSC_SLEEP = 4'h2,
    SSC_LEAD = 4'h4,
    SSC_AWAKE = 4'h8
  } ssc_state_t;
endpackage

// File: testbench/ssc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_stall,
  input wire logic mem_sleep,
  input wire logic mem_enable,
  input wire logic shutdown_in,
  input wire logic shutdown_out,
  input wire logic shutdown_oe,
  input wire logic pwm_shutoff
);
  // Every check runs on the processor clock and rests during reset.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_sleep_wr;
    sfr_wr && sfr_addr == 8'hc4 && sfr_wdata != 8'h00;
  endsequence
  sequence s_kill_wr;
    sfr_wr && sfr_addr == 8'he5 && !sfr_wdata[0];
  endsequence
  a_sleep_starts: assert property (s_sleep_wr |=> mem_sleep [*8])
    else $error("sleep did not start");
  a_sleep_stalls: assert property (mem_sleep |-> core_stall)
    else $error("core ran while asleep");
  a_sleep_disables: assert property (mem_sleep |-> !mem_enable)
    else $error("memory enabled while asleep");
  a_lead_holds: assert property ($fell(mem_sleep) && $past(reset_n, 2) |-> core_stall)
    else $error("no lead after wakeup");
  a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_never_high: assert property (shutdown_out == 1'b0)
    else $error("shutdown line driven high");
  a_kill_drives: assert property (s_kill_wr |=> shutdown_oe)
    else $error("shutdown not asserted");
  a_ext_shutoff: assert property (!shutdown_in |=> pwm_shutoff)
    else $error("pwm kept on");
endmodule // ssc_monitor
`default_nettype wire

// File: testbench/ssc_gate_line.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_gate_line (
  input wire logic shutdown_out,
  input wire logic shutdown_oe,
  input wire logic ext_pull_low,
  output logic shutdown_in
);
  // Pulled-up wire: any party pulling low wins, otherwise it rests high.
  assign shutdown_in = ((shutdown_oe && !shutdown_out) || ext_pull_low) ? 1'b0 : 1'b1;
endmodule // ssc_gate_line
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic itrip_trigger = 1'b0;
  logic ext_pull_low = 1'b0;
  logic [7:0] sfr_rdata;
  logic core_stall, mem_sleep, mem_enable, opcode_trap_sel, shutdown_in, shutdown_out, shutdown_oe, pwm_shutoff;
  logic single_shunt_amp_enable, leg_shunt_amp_enable, ac_sense_amp_enable;
  int n_errors = 0;
  int checks = 0;
  int n_sleep, n_stall;
  logic [7:0] ra[8] = '{8'ha2, 8'hb2, 8'hc4, 8'hc5, 8'hdc, 8'he5, 8'hdb, 8'h10};
  logic [7:0] re[8] = '{8'h00, 8'h01, 8'h00, 8'h00, ssc_pkg::REVISION_CODE, 8'h00, 8'h00, 8'h00};
  logic [7:0] wa[5] = '{8'ha2, 8'hb2, 8'hdc, 8'he5, 8'h10};
  logic [7:0] wd[5] = '{8'hff, 8'hf5, 8'hff, 8'hf1, 8'hff};
  logic [7:0] we[5] = '{8'h10, 8'h15, ssc_pkg::REVISION_CODE, 8'h01, 8'h00};
  // Processor clock at 20 MHz.
  always #25 ref_clk = ~ref_clk;
  ssc_top #(.FLASH_VARIANT(1'b0)) ssc_top_i (.ref_clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .core_stall, .mem_sleep, .mem_enable, .opcode_trap_sel, .single_shunt_amp_enable,
    .leg_shunt_amp_enable, .ac_sense_amp_enable, .itrip_trigger, .shutdown_in, .shutdown_out, .shutdown_oe,
    .pwm_shutoff);
  ssc_gate_line ssc_gate_line_i (.shutdown_out, .shutdown_oe, .ext_pull_low, .shutdown_in);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, exp);
  endtask
  // Counts sleeping and stalled cycles over a fixed span.
  task automatic meas();
    n_sleep = 0;
    n_stall = 0;
    repeat (60) begin
      #1 n_sleep += int'(mem_sleep);
      n_stall += int'(core_stall);
      @(posedge ref_clk);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 chk({7'h0, shutdown_oe}, 8'h01);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], re[i]);
    foreach (wa[i]) begin
      wr(wa[i], wd[i]);
      rd(wa[i], we[i]);
    end
    chk({4'h0, opcode_trap_sel, ac_sense_amp_enable, leg_shunt_amp_enable, single_shunt_amp_enable}, 8'h0f);
    chk({6'h00, shutdown_oe, pwm_shutoff}, 8'h00);
    ext_pull_low <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk({7'h0, pwm_shutoff}, 8'h01);
    ext_pull_low <= 1'b0;
    wr(8'he5, 8'h05);
    itrip_trigger <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk({7'h0, shutdown_oe}, 8'h01);
    itrip_trigger <= 1'b0;
    wr(8'hdb, 8'h30);
    wr(8'hc4, 8'h02);
    meas();
    chk(8'(n_sleep), 8'd32);
    chk(8'(n_stall), 8'd39);
    wr(8'hc4, 8'h00);
    meas();
    chk(8'(n_stall), 8'd0);
    wr(8'hc5, 8'h04);
    wr(8'hc4, 8'h01);
    meas();
    chk({7'h0, n_sleep > 16}, 8'h01);
    wr(8'hc5, 8'h00);
    meas();
    meas();
    chk(8'(n_sleep), 8'd0);
    wr(8'he5, 8'h00);
    #1 chk({7'h0, shutdown_oe}, 8'h01);
    test_done();
  end
  // Watchdog against a hang.
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule // tb_top
bind ssc_top ssc_monitor ssc_monitor_i (.ref_clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
  .sfr_rdata, .core_stall, .mem_sleep, .mem_enable, .shutdown_in, .shutdown_out, .shutdown_oe, .pwm_shutoff);
`default_nettype wire
